/* common/ppo_defines.svh */
// Purpose: Constants of the position PWM output stage
// Assumes: 200 MHz aclk, duty counted in 1000 steps per period
// Notes:   Register byte address is four times its index
`ifndef PPO_DEFINES_SVH
`define PPO_DEFINES_SVH
// Clock and carrier frequencies in Hz
`define PPO_CLK_HZ      32'h0BEB_C200
`define PPO_F0_HZ       32'h0000_007D
`define PPO_F1_HZ       32'h0000_00FA
`define PPO_F2_HZ       32'h0000_01F4
`define PPO_F3_HZ       32'h0000_02EE
`define PPO_F4_HZ       32'h0000_03E8
`define PPO_F5_HZ       32'h0000_04E2
`define PPO_F6_HZ       32'h0000_05DC
`define PPO_F7_HZ       32'h0000_07D0
// Duty steps per period (0.1 % each)
`define PPO_STEPS       32'h0000_03E8
`define PPO_STEPS_HALF  32'h0000_01F4
`define PPO_PHASE_LAST  10'h3E7
`define PPO_DUTY_MIN    10'h032
`define PPO_DUTY_MAX    10'h3B6
`define PPO_DIAG_LO     10'h019
`define PPO_DIAG_HI     10'h3CF
`define PPO_CLAMP_STEP  10'h009
`define PPO_SPAN_MUL    11'h385
`define PPO_SPAN_SH     10
`define PPO_CODE_MAX    10'h3FF
`define PPO_GAIN_SH     16
// Clamp settings in percent
`define PPO_LCL_MIN     7'h05
`define PPO_LCL_MAX     7'h44
`define PPO_UCL_MIN     7'h20
`define PPO_UCL_MAX     7'h5F
// Register indices
`define PPO_IDX_CTRL    3'h0
`define PPO_IDX_ZERO    3'h1
`define PPO_IDX_GAIN    3'h2
`define PPO_IDX_CLAMP   3'h3
`define PPO_IDX_STAT    3'h4
`define PPO_IDX_MASK    3'h5
`define PPO_IDX_STATE   3'h6
`define PPO_IDX_DUTY    3'h7
// Control bits
`define PPO_CTRL_EN     0
`define PPO_CTRL_FSEL   1
`define PPO_CTRL_FALL   4
`define PPO_CTRL_SAW    5
`define PPO_CTRL_DHI    6
`define PPO_UCL_LSB     8
// Status bits
`define PPO_ST_FRISE    0
`define PPO_ST_FFALL    1
`define PPO_ST_PER      2
`define PPO_ST_CLERR    3
// Reset values
`define PPO_RST_CTRL    7'h00
`define PPO_RST_ZERO    16'h0000
`define PPO_RST_GAIN    16'h0400
`define PPO_RESP_OKAY   2'h0
`define PPO_RESP_SLVERR 2'h2
`endif

/* common/ppo_pkg.sv */
// Purpose: Types of the position PWM output stage
// Assumes: Nothing
// Notes:   Constants live in ppo_defines.svh
`default_nettype none
package ppo_pkg;
  typedef enum logic [2:0] {
    PPO_F0125, PPO_F0250, PPO_F0500, PPO_F0750,
    PPO_F1000, PPO_F1250, PPO_F1500, PPO_F2000
  } ppo_freq_e;
  typedef enum logic [1:0] {PPO_MODE_OFF, PPO_MODE_POS, PPO_MODE_DIAG} ppo_mode_e;
  typedef logic [9:0] ppo_code_t;
endpackage
`default_nettype wire

/* rtl/ppo_tick_div.sv */
// Purpose: Step enable, 1000 pulses per carrier period
// Assumes: Single clock
// Notes:   Divide ratio rounded to nearest, well inside 7 %
`timescale 1ns/1ps
`default_nettype none
`include "ppo_defines.svh"
module ppo_tick_div #(
  parameter int unsigned CLK_HZ = `PPO_CLK_HZ
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              en,
  input  wire ppo_pkg::ppo_freq_e fsel,
  output logic                   tick
);
  logic [10:0] cnt_r, cnt_nxt;
  logic        tick_r, tick_nxt;

  function automatic logic [10:0] presc(input ppo_pkg::ppo_freq_e s);
    int unsigned f;
    f = `PPO_F0_HZ;
    unique case (s)
      ppo_pkg::PPO_F0125: f = `PPO_F0_HZ;
      ppo_pkg::PPO_F0250: f = `PPO_F1_HZ;
      ppo_pkg::PPO_F0500: f = `PPO_F2_HZ;
      ppo_pkg::PPO_F0750: f = `PPO_F3_HZ;
      ppo_pkg::PPO_F1000: f = `PPO_F4_HZ;
      ppo_pkg::PPO_F1250: f = `PPO_F5_HZ;
      ppo_pkg::PPO_F1500: f = `PPO_F6_HZ;
      ppo_pkg::PPO_F2000: f = `PPO_F7_HZ;
    endcase
    return 11'((CLK_HZ + f * `PPO_STEPS_HALF) / (f * `PPO_STEPS) - 1);
  endfunction

  always_comb begin
    cnt_nxt  = cnt_r + 11'h001;
    tick_nxt = 1'b0;
    if (!en) begin
      cnt_nxt = 11'h000;
    end else if (cnt_r >= presc(fsel)) begin
      cnt_nxt  = 11'h000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  a_tick_gap: assert property (
    @(posedge aclk) disable iff (!aresetn) tick_r |-> $past(cnt_r) >= presc($past(fsel)))
    else $error("Step pulse came before the divide ratio was reached");
endmodule // ppo_tick_div
`default_nettype wire

/* rtl/ppo_pos_map.sv */
// Purpose: Angle to 10-bit output code transfer
// Assumes: Angle is 16 bits over one electrical turn
// Notes:   Code is registered, updated on each valid angle
`timescale 1ns/1ps
`default_nettype none
`include "ppo_defines.svh"
module ppo_pos_map (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [15:0]       angle,
  input  wire logic              angle_valid,
  input  wire logic [15:0]       zero,
  input  wire logic [15:0]       gain,
  input  wire logic              sawtooth,
  input  wire logic              falling,
  output ppo_pkg::ppo_code_t     code
);
  logic [15:0]        rel;
  logic [31:0]        prod;
  logic [15:0]        scaled;
  ppo_pkg::ppo_code_t raw;
  ppo_pkg::ppo_code_t code_r, code_nxt;

  always_comb begin
    rel    = angle - zero;
    prod   = 32'(rel) * 32'(gain);
    scaled = prod[`PPO_GAIN_SH +: 16];
    if (sawtooth) begin
      raw = scaled[9:0];
    end else if (scaled > 16'(`PPO_CODE_MAX)) begin
      raw = `PPO_CODE_MAX;
    end else begin
      raw = scaled[9:0];
    end
  end

  always_comb begin
    code_nxt = code_r;
    if (angle_valid) begin
      code_nxt = falling ? (`PPO_CODE_MAX - raw) : raw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_r <= 10'h000;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign code = code_r;

  a_lin_saturate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (angle_valid && !sawtooth && scaled > 16'(`PPO_CODE_MAX))
    |=> code_r == ($past(falling) ? 10'h000 : `PPO_CODE_MAX))
    else $error("Linear slope did not saturate at the range end");
  a_dir_mirror: assert property (
    @(posedge aclk) disable iff (!aresetn)
    angle_valid |=> code_r + $past(raw) == ($past(falling) ? `PPO_CODE_MAX : 2 * $past(raw)))
    else $error("Output code does not follow the slope direction");
endmodule // ppo_pos_map
`default_nettype wire

/* rtl/ppo_top.sv */
// Purpose: Position PWM output stage with AXI4-Lite registers
// Assumes: Angle and fault inputs come from logic on aclk
// Notes:   Open-drain pin, high portion of the period is the duty
// How it works
// - Carrier from eight selectable rates, 125 Hz to 2 kHz, within 7 percent.
// - Full position span maps linearly onto 5 to 95 percent duty.
// - Each clamp percent step moves its duty limit by 0.9 percent.
// - Low diagnostic level is 2.5 percent duty, never above 4.
// - High diagnostic level is 97.5 percent duty, never below 96.
// - Lower clamp 5 to 68, upper 32 to 95; duty kept between.
// - Transfer adjusted by zero offset and linear or sawtooth slope.
// - A control bit picks rising or falling output versus angle.
// - Output code is 10 bits, 0 lower range end, 1023 upper end.
// - Coil, frequency, oscillator, magnitude, target, memory, overflow faults watched.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_defines.svh"
module ppo_top #(
  parameter int unsigned CLK_HZ = `PPO_CLK_HZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] angle_in,
  input  wire logic        angle_valid,
  input  wire logic [6:0]  fault_in,
  output logic             pwm_pin_o,
  output logic             pwm_pin_oe,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding and byte lanes
  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    return {(a[7:5] != 3'h0) || (a[1:0] != 2'h0), a[4:2]};
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [6:0] sat7(input logic [6:0] v,
                                      input logic [6:0] lo,
                                      input logic [6:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake
  logic        aw_have_r, aw_have_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic        w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        do_wr;
  logic [3:0]  wr_idx;
  logic [3:0]  rd_idx;
  logic [31:0] rd_word;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign do_wr         = aw_have_r && w_have_r && !bvalid_r;
  assign wr_idx        = reg_idx(aw_addr_r);
  assign rd_idx        = reg_idx(s_axi_araddr);

  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_idx[3] ? `PPO_RESP_SLVERR : `PPO_RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_idx[3] ? 32'h0000_0000 : rd_word;
      rresp_nxt  = rd_idx[3] ? `PPO_RESP_SLVERR : `PPO_RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PPO_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= `PPO_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [6:0]  ctrl_r, ctrl_nxt;
  logic [15:0] zero_r, zero_nxt;
  logic [15:0] gain_r, gain_nxt;
  logic [6:0]  lcl_r, lcl_nxt;
  logic [6:0]  ucl_r, ucl_nxt;
  logic [3:0]  stat_r, stat_nxt;
  logic [3:0]  mask_r, mask_nxt;
  logic        irq_r, irq_nxt;
  logic [31:0] wv;
  logic [3:0]  events;

  always_comb begin
    ctrl_nxt = ctrl_r;
    zero_nxt = zero_r;
    gain_nxt = gain_r;
    lcl_nxt  = lcl_r;
    ucl_nxt  = ucl_r;
    mask_nxt = mask_r;
    wv       = 32'h0000_0000;
    // Set wins over a write-one clear in the same cycle
    stat_nxt = stat_r | events;
    if (do_wr && !wr_idx[3]) begin
      unique case (wr_idx[2:0])
        `PPO_IDX_CTRL: begin
          wv       = lanes({25'h0, ctrl_r}, w_data_r, w_strb_r);
          ctrl_nxt = wv[6:0];
        end
        `PPO_IDX_ZERO: begin
          wv       = lanes({16'h0, zero_r}, w_data_r, w_strb_r);
          zero_nxt = wv[15:0];
        end
        `PPO_IDX_GAIN: begin
          wv       = lanes({16'h0, gain_r}, w_data_r, w_strb_r);
          gain_nxt = wv[15:0];
        end
        `PPO_IDX_CLAMP: begin
          wv = lanes({17'h0, ucl_r, 1'b0, lcl_r}, w_data_r, w_strb_r);
          lcl_nxt = sat7(wv[6:0], `PPO_LCL_MIN, `PPO_LCL_MAX);
          ucl_nxt = sat7(wv[`PPO_UCL_LSB +: 7], `PPO_UCL_MIN, `PPO_UCL_MAX);
        end
        `PPO_IDX_STAT: begin
          wv       = lanes(32'h0000_0000, w_data_r, w_strb_r);
          stat_nxt = (stat_r & ~wv[3:0]) | events;
        end
        `PPO_IDX_MASK: begin
          wv       = lanes({28'h0, mask_r}, w_data_r, w_strb_r);
          mask_nxt = wv[3:0];
        end
        `PPO_IDX_STATE, `PPO_IDX_DUTY: begin
          wv = 32'h0000_0000;
        end
      endcase
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `PPO_RST_CTRL;
      zero_r <= `PPO_RST_ZERO;
      gain_r <= `PPO_RST_GAIN;
      lcl_r  <= `PPO_LCL_MIN;
      ucl_r  <= `PPO_UCL_MAX;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      irq_r  <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      zero_r <= zero_nxt;
      gain_r <= gain_nxt;
      lcl_r  <= lcl_nxt;
      ucl_r  <= ucl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Position mapping and timebase
  ppo_pkg::ppo_code_t code;
  logic               tick;
  logic               run;

  assign run = ctrl_r[`PPO_CTRL_EN];

  ppo_pos_map u_map (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .angle       (angle_in),
    .angle_valid (angle_valid),
    .zero        (zero_r),
    .gain        (gain_r),
    .sawtooth    (ctrl_r[`PPO_CTRL_SAW]),
    .falling     (ctrl_r[`PPO_CTRL_FALL]),
    .code        (code)
  );

  ppo_tick_div #(.CLK_HZ(CLK_HZ)) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (run),
    .fsel    (ppo_pkg::ppo_freq_e'(ctrl_r[`PPO_CTRL_FSEL +: 3])),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Duty selection
  logic [9:0]         lo_lim, hi_lim, pos_duty, duty_sel;
  logic [20:0]        span;
  logic               fault_act;
  ppo_pkg::ppo_mode_e mode;

  assign fault_act = |fault_in;

  always_comb begin
    lo_lim = `PPO_DUTY_MIN + `PPO_CLAMP_STEP * 10'(lcl_r - `PPO_LCL_MIN);
    hi_lim = `PPO_DUTY_MAX - `PPO_CLAMP_STEP * 10'(`PPO_UCL_MAX - ucl_r);
    span     = 21'(code) * 21'(`PPO_SPAN_MUL);
    pos_duty = `PPO_DUTY_MIN + span[`PPO_SPAN_SH +: 10];
    mode     = !run ? ppo_pkg::PPO_MODE_OFF :
               (fault_act ? ppo_pkg::PPO_MODE_DIAG : ppo_pkg::PPO_MODE_POS);
    duty_sel = pos_duty;
    unique case (mode)
      ppo_pkg::PPO_MODE_OFF,
      ppo_pkg::PPO_MODE_POS: begin
        if (pos_duty < lo_lim) begin
          duty_sel = lo_lim;
        end else if (pos_duty > hi_lim) begin
          duty_sel = hi_lim;
        end
      end
      ppo_pkg::PPO_MODE_DIAG: begin
        duty_sel = ctrl_r[`PPO_CTRL_DHI] ? `PPO_DIAG_HI : `PPO_DIAG_LO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period engine and open-drain pin
  logic [9:0] phase_r, phase_nxt;
  logic [9:0] duty_r, duty_nxt;
  logic       oe_r, oe_nxt;
  logic       fault_q_r;
  logic       per_end;

  assign per_end = run && tick && (phase_r == `PPO_PHASE_LAST);

  always_comb begin
    phase_nxt = phase_r;
    duty_nxt  = duty_r;
    if (!run) begin
      phase_nxt = 10'h000;
      duty_nxt  = duty_sel;
    end else if (per_end) begin
      // While running, new duty taken only at a period boundary
      phase_nxt = 10'h000;
      duty_nxt  = duty_sel;
    end else if (tick) begin
      phase_nxt = phase_r + 10'h001;
    end
    // Pin released (high) for the first duty steps
    oe_nxt = !(run && (phase_nxt < duty_nxt));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r   <= 10'h000;
      duty_r    <= `PPO_DUTY_MIN;
      oe_r      <= 1'b1;
      fault_q_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      duty_r    <= duty_nxt;
      oe_r      <= oe_nxt;
      fault_q_r <= fault_act;
    end
  end

  assign pwm_pin_o  = 1'b0;
  assign pwm_pin_oe = oe_r;

  always_comb begin
    events                 = 4'h0;
    events[`PPO_ST_FRISE] = fault_act && !fault_q_r;
    events[`PPO_ST_FFALL] = !fault_act && fault_q_r;
    events[`PPO_ST_PER]   = per_end;
    events[`PPO_ST_CLERR] = lcl_r >= ucl_r;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_idx[2:0])
      `PPO_IDX_CTRL:  rd_word = {25'h0, ctrl_r};
      `PPO_IDX_ZERO:  rd_word = {16'h0, zero_r};
      `PPO_IDX_GAIN:  rd_word = {16'h0, gain_r};
      `PPO_IDX_CLAMP: rd_word = {17'h0, ucl_r, 1'b0, lcl_r};
      `PPO_IDX_STAT:  rd_word = {28'h0, stat_r};
      `PPO_IDX_MASK:  rd_word = {28'h0, mask_r};
      `PPO_IDX_STATE: rd_word = {6'h0, run, fault_q_r, 1'b0, fault_in, 6'h0, code};
      `PPO_IDX_DUTY:  rd_word = {6'h0, phase_r, 6'h0, duty_r};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_duty_band: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (per_end && !fault_act) |=> duty_r >= `PPO_DUTY_MIN && duty_r <= `PPO_DUTY_MAX)
    else $error("Position duty outside 5 to 95 percent");
  a_clamp_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (lcl_r == $past(lcl_r) + 7'h01) |-> lo_lim == $past(lo_lim) + `PPO_CLAMP_STEP)
    else $error("Lower clamp step did not move limit by nine steps");
  a_diag_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (per_end && fault_act && !ctrl_r[`PPO_CTRL_DHI]) |=> duty_r == `PPO_DIAG_LO ##1 !oe_r)
    else $error("Low diagnostic duty not 2.5 percent");
  a_diag_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (per_end && fault_act && ctrl_r[`PPO_CTRL_DHI]) |=> duty_r == `PPO_DIAG_HI)
    else $error("High diagnostic duty not 97.5 percent");
  a_clamp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (per_end && !fault_act) |=> duty_r >= $past(lo_lim) && duty_r <= $past(hi_lim))
    else $error("Duty escaped the clamp band");
  a_fault_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (fault_act && !fault_q_r) |=> stat_r[`PPO_ST_FRISE])
    else $error("Fault onset not recorded in status");
  a_fault_resume: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (per_end && !fault_act && pos_duty >= lo_lim && pos_duty <= hi_lim)
    |=> duty_r == $past(pos_duty))
    else $error("Position output did not resume after the fault");
  a_period_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    per_end |=> phase_r == 10'h000 ##1 oe_r == (duty_r == 10'h000))
    else $error("Period counter did not wrap after 1000 steps");
endmodule // ppo_top
`default_nettype wire

/* testbench/ppo_host_model.sv */
// Purpose: Host that samples the open-drain pin
// Assumes: Pull-up on the pin
// Notes:   Widths counted in aclk cycles
`timescale 1ns/1ps
`default_nettype none
module ppo_host_model (
  input  wire logic aclk,
  input  wire logic pin_oe,
  output int        high_cnt,
  output int        per_cnt,
  output logic      diag
);
  int   cnt;
  logic lvl;
  logic lvl_d = 1'b0;
  assign lvl  = (pin_oe === 1'b0);
  assign diag = (high_cnt * 20 < per_cnt) || (high_cnt * 20 > 19 * per_cnt);
  always @(posedge aclk) begin
    lvl_d <= lvl;
    cnt   <= (lvl && !lvl_d) ? 1 : cnt + 1;
    if (lvl && !lvl_d) per_cnt <= cnt;
    if (!lvl && lvl_d) high_cnt <= cnt;
  end
endmodule // ppo_host_model
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench of the PWM output stage
// Assumes: CLK_HZ lowered so steps are 1 or 2 cycles
// Notes:   AXI4-Lite master samples ready at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk = 0, aresetn = 0, vld = 1, done;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] angle_in = 0;
  logic [6:0]  fault_in = 0;
  logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq, diag;
  int          high_cnt, per_cnt, num_errors = 0, n_compared = 0, cyc = 0;
  int          zr = 0, gn = 1024, lc = 5, uc = 95, fall = 0, saw = 0;
  always #2.5 aclk = ~aclk;
  ppo_top #(.CLK_HZ(2_000_000)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .angle_in(angle_in), .angle_valid(vld), .fault_in(fault_in),
    .pwm_pin_o(pin_o), .pwm_pin_oe(pin_oe), .irq(irq));
  ppo_host_model host (.aclk(aclk), .pin_oe(pin_oe), .high_cnt(high_cnt),
    .per_cnt(per_cnt), .diag(diag));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      end_sim;
    end
  end
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      done = bvalid;
      rs = bresp;
    end
    bready <= 0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      done = rvalid;
      rd = rdata;
      rs = rresp;
    end
    rready <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function int exp_code(input int ang);
    longint c;
    c = (longint'((ang - zr) & 65535) * gn) >> 16;
    if (saw != 0) c = c & 1023;
    else if (c > 1023) c = 1023;
    if (fall != 0) c = 1023 - c;
    return int'(c);
  endfunction
  function int exp_duty(input int c);
    int d;
    d = 50 + ((c * 901) >> 10);
    if (d < 50 + 9 * (lc - 5)) d = 50 + 9 * (lc - 5);
    else if (d > 950 - 9 * (95 - uc)) d = 950 - 9 * (95 - uc);
    return d;
  endfunction
  task pos(input int ang, input int per);
    int c;
    c = exp_code(ang);
    angle_in <= 16'(ang);
    repeat (3 * per + 100) @(posedge aclk);
    axr(8'h18);
    chk(rd[9:0], c);
    axr(8'h1C);
    chk(rd[9:0], exp_duty(c));
    chk(high_cnt, exp_duty(c) * per / 1000);
    chk(per_cnt, per);
    $display("position test done, angle %h", ang[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(92198));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    axr(8'h0C);
    chk(rd, 32'h0000_5F05);
    axr(8'h20);
    chk(rd, 32'h0000_0000);
    chk(rs, 2'h2);
    axw(8'h0C, 32'h0000_7F7F);
    axr(8'h0C);
    chk(rd, 32'h0000_5F44);
    axw(8'h0C, 32'h0000_5F05);
    axw(8'h14, 32'h0000_0003);
    $display("register test done");
    axw(8'h00, 32'h0000_0009);
    pos(32'h8000, 2000);
    axw(8'h00, 32'h0000_000F);
    for (int i = 0; i < 3; i++) pos($urandom, 1000);
    fall = 1;
    axw(8'h00, 32'h0000_001F);
    pos($urandom, 1000);
    fall = 0; zr = 32'h4000; gn = 32'h0800;
    axw(8'h04, 32'h0000_4000);
    axw(8'h08, 32'h0000_0800);
    axw(8'h00, 32'h0000_000F);
    pos(32'hC000, 1000);
    saw = 1;
    axw(8'h00, 32'h0000_002F);
    pos(32'hC000, 1000);
    saw = 0; lc = 21; uc = 60;
    axw(8'h00, 32'h0000_000F);
    axw(8'h0C, 32'h0000_3C14);
    axw(8'h0C, 32'h0000_3C15);
    pos(32'h4000, 1000);
    pos(32'hFFFF, 1000);
    fault_in <= 7'(1 << ($urandom % 7));
    repeat (3100) @(posedge aclk);
    axr(8'h1C);
    chk({rd[9:0], irq, diag}, {10'h019, 2'b11});
    axw(8'h00, 32'h0000_004F);
    repeat (3100) @(posedge aclk);
    axr(8'h1C);
    chk({rd[9:0], high_cnt[9:0], diag}, {10'h3CF, 10'h3CF, 1'b1});
    axw(8'h14, 32'h0000_0000);
    chk(irq, 1'b0);
    fault_in <= 7'h00;
    axw(8'h14, 32'h0000_0003);
    axw(8'h10, 32'h0000_0003);
    axr(8'h10);
    chk({rd[1:0], irq, pin_o}, 4'b0000);
    $display("fault test done");
    vld <= 0;
    angle_in <= 16'h4010;
    repeat (5) @(posedge aclk);
    axr(8'h18);
    chk(rd[9:0], exp_code(32'hFFFF));
    vld <= 1;
    $display("angle hold test done");
    pos(32'hFFFF, 1000);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
